// [uart_regs.vh]
`ifndef UART_REGS_VH
`define UART_REGS_VH
// Summary of operation
// - The 16x tick runs at the core clock over 2^exponent times 2 times the 16-bit divisor.
// - With the fractional divider on, each tick period is further stretched by M + N/2048.
// - Frames are asynchronous, with word length, stop bits and parity set in line control.
// - An 8-bit transmit holding register takes the next character to be sent.
// - An 8-bit read-only receive buffer returns the most recently received character.
// - The data registers and the low divisor latch share one address, picked by line control bit 7.
// - Interrupt enable bit 3 raises the interrupt while any of modem status bits 3 to 1 is set.
// - Interrupt enable bit 2 raises the interrupt while any of line status bits 4 to 1 is set.
// - Interrupt enable bit 1 raises the interrupt when the transmit buffer empties.
// - Interrupt enable bit 0 raises the interrupt when the receive buffer fills.
// - Twelve registers are visible to software, from transmit data to the fractional divider.
// - Interrupt enable bits 7 to 4 are reserved and never affect the interrupt.

// ==========================================================================
// Register byte addresses.
`define ADDR_DATA 32'hFFFF0700
`define ADDR_IEN 32'hFFFF0704
`define ADDR_IID 32'hFFFF0708
`define ADDR_LCR 32'hFFFF070C
`define ADDR_MCR 32'hFFFF0710
`define ADDR_LSR 32'hFFFF0714
`define ADDR_MSR 32'hFFFF0718
`define ADDR_SCR 32'hFFFF071C
`define ADDR_FRAC 32'hFFFF072C

// ==========================================================================
// Reset values.
`define RST_BYTE 8'h00
`define RST_FRAC 16'h0000

// ==========================================================================
// Line control fields.
`define LCR_WLEN_LO 0
`define LCR_STOP 2
`define LCR_PEN 3
`define LCR_EVEN 4
`define LCR_STICK 5
`define LCR_BREAK 6
`define LCR_DLAB 7

// ==========================================================================
// Fractional divider fields.
`define FRAC_N_HI 10
`define FRAC_M_LO 11
`define FRAC_M_HI 12
`define FRAC_EN 15

// ==========================================================================
// Interrupt status and enable bit positions.
`define IRQ_RXFULL 0
`define IRQ_TXEMPTY 1
`define IRQ_RXSTAT 2
`define IRQ_MODEM 3

// ==========================================================================
// Bit timing on the 16x tick.
`define TICK_LAST 4'hF
`define TICK_MID 4'h7
`endif

// [baud_gen.v]
`include "uart_regs.vh"

// ==========================================================================
// Baud tick generator: power-of-two prescale, divisor, fractional stretch.
module baud_gen (
  input wire pclk,
  input wire presetn,
  input wire [2:0] clock_div_exponent,
  input wire [15:0] divisor_value,
  input wire frac_en,
  input wire [1:0] frac_m,
  input wire [10:0] frac_n,
  output reg tick16
);
  reg [7:0] pre_cnt;
  reg [15:0] div_cnt;
  reg [2:0] unit_cnt;
  reg [10:0] frac_acc;
  wire [8:0] pre_span = 9'h002 << clock_div_exponent;
  wire [7:0] pre_top = pre_span[7:0] - 8'h01;
  wire pre_tick = (pre_cnt == pre_top);
  wire unit_tick = pre_tick && (divisor_value != 16'h0000) && (div_cnt >= divisor_value - 16'h0001);
  wire [11:0] acc_sum = {1'b0, frac_acc} + {1'b0, frac_n};
  // An M of zero still takes one unit, so the divider never stalls.
  wire [2:0] m_units = (frac_m == 2'h0) ? 3'h1 : {1'b0, frac_m};
  wire [2:0] need = frac_en ? (m_units + {2'h0, acc_sum[11]}) : 3'h1;

  // Each unit is 2^exponent*2*divisor clocks; a tick spans one or M+N/2048 units.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 8'h00;
      div_cnt <= 16'h0000;
      unit_cnt <= 3'h0;
      frac_acc <= 11'h000;
      tick16 <= 1'b0;
    end else begin
      tick16 <= 1'b0;
      pre_cnt <= pre_tick ? 8'h00 : pre_cnt + 8'h01;
      if (unit_tick) begin
        div_cnt <= 16'h0000;
        if (unit_cnt + 3'h1 >= need) begin
          unit_cnt <= 3'h0;
          tick16 <= 1'b1;
          if (frac_en) begin
            frac_acc <= acc_sum[10:0];
          end
        end else begin
          unit_cnt <= unit_cnt + 3'h1;
        end
      end else if (pre_tick) begin
        div_cnt <= div_cnt + 16'h0001;
      end
    end
  end
endmodule

// [tx_serializer.v]
`include "uart_regs.vh"

// ==========================================================================
// Transmit shifter: sends one assembled frame, sixteen ticks per bit.
module tx_serializer (
  input wire pclk,
  input wire presetn,
  input wire tick16,
  input wire start,
  input wire [7:0] data,
  input wire [1:0] word_len,
  input wire stop_two,
  input wire parity_en,
  input wire parity_bit,
  input wire break_ctl,
  output reg txd,
  output reg busy
);
  reg [11:0] shreg;
  reg [3:0] tcnt;
  reg [3:0] bits_left;
  reg [11:0] frame;
  integer i;
  wire [3:0] len = {2'h0, word_len} + 4'h5;

  // Frame assembly: start, data LSB first, parity, then ones as stop bits.
  always @* begin
    frame = 12'hFFF;
    frame[0] = 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      if (i < len) begin
        frame[i + 1] = data[i];
      end
    end
    if (parity_en) begin
      frame[len + 4'h1] = parity_bit;
    end
  end

  // Shift out one bit per sixteen ticks until the frame is spent.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shreg <= 12'hFFF;
      tcnt <= 4'h0;
      bits_left <= 4'h0;
      busy <= 1'b0;
      txd <= 1'b1;
    end else begin
      txd <= ~break_ctl & (~busy | shreg[0]);
      if (start && !busy) begin
        shreg <= frame;
        tcnt <= 4'h0;
        bits_left <= len + 4'h2 + {3'h0, parity_en} + {3'h0, stop_two};
        busy <= 1'b1;
      end else if (busy && tick16) begin
        tcnt <= tcnt + 4'h1;
        if (tcnt == `TICK_LAST) begin
          shreg <= {1'b1, shreg[11:1]};
          bits_left <= bits_left - 4'h1;
          if (bits_left == 4'h1) begin
            busy <= 1'b0;
          end
        end
      end
    end
  end
endmodule

// [async_serial_port.v]
// Our own choice: register access over APB.
`include "uart_regs.vh"

// ==========================================================================
// Asynchronous serial port with APB register access.
module async_serial_port (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [2:0] clock_div_exponent,
  input wire rxd,
  output wire txd,
  input wire cts_n,
  input wire dsr_n,
  input wire ri_n,
  input wire dcd_n,
  output wire rts_n,
  output wire dtr_n,
  output wire irq
);
  localparam [2:0] RX_IDLE = 3'h0;
  localparam [2:0] RX_START = 3'h1;
  localparam [2:0] RX_DATA = 3'h2;
  localparam [2:0] RX_PAR = 3'h3;
  localparam [2:0] RX_STOP = 3'h4;

  // ==========================================================================
  // Register state.
  reg [7:0] tx_holding_reg;
  reg [7:0] rx_buffer_reg;
  reg [7:0] divisor_low_latch;
  reg [7:0] divisor_high_latch;
  reg [7:0] irq_enable_reg;
  reg [3:0] irq_identification_reg;
  reg [7:0] line_control_reg;
  reg [1:0] modem_control_reg;
  reg [7:0] scratch_reg;
  reg [15:0] fractional_divider_reg;
  reg hold_full;
  reg data_ready;
  reg overrun_err;
  reg parity_err;
  reg framing_err;
  reg break_int;
  reg [3:0] modem_delta;
  reg [3:0] modem_prev;

  // ==========================================================================
  // Receiver state.
  reg [2:0] rx_state;
  reg [3:0] rx_tcnt;
  reg [2:0] rx_idx;
  reg [7:0] rx_shift;
  reg rx_par_bad;
  reg rx_done;
  reg rx_done_fe;
  reg rx_done_be;
  reg [7:0] rx_word;
  reg tx_empty_evt;

  wire tick16;
  wire tx_busy;
  wire [7:0] line_status_reg;
  wire [7:0] modem_status_reg;
  wire [3:0] modem_now = {~dcd_n, ~ri_n, ~dsr_n, ~cts_n};
  wire dlab = line_control_reg[`LCR_DLAB];
  wire [1:0] word_len = line_control_reg[1:0];
  wire [7:0] word_mask = 8'hFF >> (2'h3 - word_len);
  wire [2:0] last_idx = {1'b0, word_len} + 3'h4;

  // ==========================================================================
  // APB decode.
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire rd = access & ~pwrite;
  wire hit_data = (paddr == `ADDR_DATA);
  wire hit_ien = (paddr == `ADDR_IEN);
  wire hit_iid = (paddr == `ADDR_IID);
  wire hit_lcr = (paddr == `ADDR_LCR);
  wire hit_mcr = (paddr == `ADDR_MCR);
  wire hit_lsr = (paddr == `ADDR_LSR);
  wire hit_msr = (paddr == `ADDR_MSR);
  wire hit_scr = (paddr == `ADDR_SCR);
  wire hit_frac = (paddr == `ADDR_FRAC);
  wire hit = hit_data | hit_ien | hit_iid | hit_lcr | hit_mcr | hit_lsr | hit_msr | hit_scr |
    hit_frac;

  // The slave never inserts wait states; unmapped addresses answer with an error.
  assign pready = access;
  assign pslverr = access & ~hit;

  // Parity bit for a masked word under the current line settings.
  function par_of;
    input [7:0] d;
    input even;
    input stick;
    begin
      if (stick) begin
        par_of = ~even;
      end else begin
        par_of = even ? (^d) : ~(^d);
      end
    end
  endfunction

  // ==========================================================================
  // Status views: line status bits 4 to 1 are the receive errors.
  assign line_status_reg = {1'b0, ~hold_full & ~tx_busy, ~hold_full, break_int, framing_err,
    parity_err, overrun_err, data_ready};
  assign modem_status_reg = {modem_now, modem_delta};
  assign rts_n = ~modem_control_reg[1];
  assign dtr_n = ~modem_control_reg[0];

  // Reserved enable bits 7 to 4 take no part in the interrupt.
  assign irq = |(irq_identification_reg & irq_enable_reg[3:0]);

  // ==========================================================================
  // Baud tick and transmit shifter.
  baud_gen baud_gen_i (
    .pclk(pclk),
    .presetn(presetn),
    .clock_div_exponent(clock_div_exponent),
    .divisor_value({divisor_high_latch, divisor_low_latch}),
    .frac_en(fractional_divider_reg[`FRAC_EN]),
    .frac_m(fractional_divider_reg[`FRAC_M_HI:`FRAC_M_LO]),
    .frac_n(fractional_divider_reg[`FRAC_N_HI:0]),
    .tick16(tick16)
  );

  // Hand the holding byte to the shifter as soon as the shifter is idle.
  wire tx_start = hold_full & ~tx_busy;

  tx_serializer tx_serializer_i (
    .pclk(pclk),
    .presetn(presetn),
    .tick16(tick16),
    .start(tx_start),
    .data(tx_holding_reg & word_mask),
    .word_len(word_len),
    .stop_two(line_control_reg[`LCR_STOP]),
    .parity_en(line_control_reg[`LCR_PEN]),
    .parity_bit(par_of(tx_holding_reg & word_mask, line_control_reg[`LCR_EVEN],
      line_control_reg[`LCR_STICK])),
    .break_ctl(line_control_reg[`LCR_BREAK]),
    .txd(txd),
    .busy(tx_busy)
  );

  // ==========================================================================
  // Read data is captured in the setup phase so it comes from a flip-flop.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup) begin
      prdata <= 32'h00000000;
      if (hit_data) begin
        prdata[7:0] <= dlab ? divisor_low_latch : rx_buffer_reg;
      end else if (hit_ien) begin
        prdata[7:0] <= dlab ? divisor_high_latch : irq_enable_reg;
      end else if (hit_iid) begin
        prdata[3:0] <= irq_identification_reg;
      end else if (hit_lcr) begin
        prdata[7:0] <= line_control_reg;
      end else if (hit_mcr) begin
        prdata[1:0] <= modem_control_reg;
      end else if (hit_lsr) begin
        prdata[7:0] <= line_status_reg;
      end else if (hit_msr) begin
        prdata[7:0] <= modem_status_reg;
      end else if (hit_scr) begin
        prdata[7:0] <= scratch_reg;
      end else if (hit_frac) begin
        prdata[15:0] <= fractional_divider_reg;
      end
    end
  end

  // ==========================================================================
  // Receiver: start bit checked at mid-bit, later bits sampled every 16 ticks.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= RX_IDLE;
      rx_tcnt <= 4'h0;
      rx_idx <= 3'h0;
      rx_shift <= 8'h00;
      rx_par_bad <= 1'b0;
      rx_done <= 1'b0;
      rx_done_fe <= 1'b0;
      rx_done_be <= 1'b0;
      rx_word <= 8'h00;
    end else begin
      rx_done <= 1'b0;
      if (tick16) begin
        rx_tcnt <= rx_tcnt + 4'h1;
        case (rx_state)
          RX_IDLE: begin
            rx_tcnt <= 4'h0;
            if (!rxd) begin
              rx_state <= RX_START;
            end
          end
          RX_START: begin
            if (rx_tcnt == `TICK_MID) begin
              rx_tcnt <= 4'h0;
              rx_idx <= 3'h0;
              // A glitch shorter than half a bit is not a start bit.
              rx_state <= rxd ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (rx_tcnt == `TICK_LAST) begin
              rx_shift <= {rxd, rx_shift[7:1]};
              rx_idx <= rx_idx + 3'h1;
              if (rx_idx == last_idx) begin
                rx_state <= line_control_reg[`LCR_PEN] ? RX_PAR : RX_STOP;
              end
            end
          end
          RX_PAR: begin
            if (rx_tcnt == `TICK_LAST) begin
              rx_par_bad <= rxd ^ par_of(rx_shift >> (2'h3 - word_len),
                line_control_reg[`LCR_EVEN], line_control_reg[`LCR_STICK]);
              rx_state <= RX_STOP;
            end
          end
          RX_STOP: begin
            if (rx_tcnt == `TICK_LAST) begin
              // Only the first stop bit is checked so the next start is not missed.
              rx_word <= rx_shift >> (2'h3 - word_len);
              rx_done_fe <= ~rxd;
              rx_done_be <= ~rxd & (rx_shift == 8'h00);
              rx_done <= 1'b1;
              rx_state <= RX_IDLE;
            end
          end
          default: begin
            rx_state <= RX_IDLE;
          end
        endcase
      end
      if (rx_state == RX_IDLE && !tick16) begin
        rx_par_bad <= rx_par_bad & ~rx_done;
      end
    end
  end

  // ==========================================================================
  // Register writes, read side effects and flag updates; a hardware set wins
  // over a clear that lands in the same cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_holding_reg <= `RST_BYTE;
      rx_buffer_reg <= `RST_BYTE;
      divisor_low_latch <= `RST_BYTE;
      divisor_high_latch <= `RST_BYTE;
      irq_enable_reg <= `RST_BYTE;
      irq_identification_reg <= 4'h0;
      line_control_reg <= `RST_BYTE;
      modem_control_reg <= 2'h0;
      scratch_reg <= `RST_BYTE;
      fractional_divider_reg <= `RST_FRAC;
      hold_full <= 1'b0;
      data_ready <= 1'b0;
      overrun_err <= 1'b0;
      parity_err <= 1'b0;
      framing_err <= 1'b0;
      break_int <= 1'b0;
      modem_delta <= 4'h0;
      modem_prev <= 4'h0;
      tx_empty_evt <= 1'b0;
    end else begin
      modem_prev <= modem_now;
      tx_empty_evt <= tx_start;
      // Software writes.
      if (wr) begin
        if (hit_data && dlab) begin
          divisor_low_latch <= pwdata[7:0];
        end
        if (hit_data && !dlab) begin
          tx_holding_reg <= pwdata[7:0];
        end
        if (hit_ien && dlab) begin
          divisor_high_latch <= pwdata[7:0];
        end
        if (hit_ien && !dlab) begin
          irq_enable_reg <= pwdata[7:0];
        end
        if (hit_iid) begin
          irq_identification_reg <= irq_identification_reg & ~pwdata[3:0];
        end
        if (hit_lcr) begin
          line_control_reg <= pwdata[7:0];
        end
        if (hit_mcr) begin
          modem_control_reg <= pwdata[1:0];
        end
        if (hit_scr) begin
          scratch_reg <= pwdata[7:0];
        end
        if (hit_frac) begin
          fractional_divider_reg <= pwdata[15:0];
        end
      end
      if (tx_start) begin
        hold_full <= 1'b0;
      end
      if (wr && hit_data && !dlab) begin
        hold_full <= 1'b1;
      end
      // Reading receive data clears data ready; reading line or modem status clears its sticky bits.
      if (rd && hit_data && !dlab) begin
        data_ready <= 1'b0;
      end
      if (rd && hit_lsr) begin
        overrun_err <= 1'b0;
        parity_err <= 1'b0;
        framing_err <= 1'b0;
        break_int <= 1'b0;
      end
      if (rd && hit_msr) begin
        modem_delta <= 4'h0;
      end
      // Hardware sets, placed last so they win.
      modem_delta[0] <= (modem_now[0] ^ modem_prev[0]) | (modem_delta[0] & ~(rd && hit_msr));
      modem_delta[1] <= (modem_now[1] ^ modem_prev[1]) | (modem_delta[1] & ~(rd && hit_msr));
      modem_delta[2] <= (~modem_now[2] & modem_prev[2]) | (modem_delta[2] & ~(rd && hit_msr));
      modem_delta[3] <= (modem_now[3] ^ modem_prev[3]) | (modem_delta[3] & ~(rd && hit_msr));
      if (rx_done) begin
        rx_buffer_reg <= rx_word;
        data_ready <= 1'b1;
        overrun_err <= overrun_err | data_ready;
        parity_err <= line_control_reg[`LCR_PEN] & rx_par_bad;
        framing_err <= rx_done_fe;
        break_int <= rx_done_be;
      end
      if (rx_done) begin
        irq_identification_reg[`IRQ_RXFULL] <= 1'b1;
      end
      if (tx_empty_evt) begin
        irq_identification_reg[`IRQ_TXEMPTY] <= 1'b1;
      end
      if (|line_status_reg[4:1]) begin
        irq_identification_reg[`IRQ_RXSTAT] <= 1'b1;
      end
      if (|modem_status_reg[3:1]) begin
        irq_identification_reg[`IRQ_MODEM] <= 1'b1;
      end
    end
  end
endmodule

// [async_serial_port_monitor.sv]
`include "uart_regs.vh"

// ==========================================================================
// Port checker for the serial port: bus decode, masks and modem lines.
module async_serial_port_monitor (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire dsr_n,
  input wire rts_n,
  input wire dtr_n,
  input wire irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic acc;
  logic mapped;
  logic dlab;
  logic [7:0] ien;

  // Access phase and address decode seen from the bus alone.
  assign acc = psel && penable;
  assign mapped = paddr inside {`ADDR_DATA, `ADDR_IEN, `ADDR_IID, `ADDR_LCR, `ADDR_MCR,
    `ADDR_LSR, `ADDR_MSR, `ADDR_SCR, `ADDR_FRAC};

  // Shadows of the bank select bit and the enable register, since the shared
  // address means an enable write only counts while the bank bit is clear.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dlab <= 1'b0;
      ien <= 8'h00;
    end else if (acc && pwrite && paddr == `ADDR_LCR) begin
      dlab <= pwdata[7];
    end else if (acc && pwrite && paddr == `ADDR_IEN && !dlab) begin
      ien <= pwdata[7:0];
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_ready_access: assert property (pready == acc)
    else $error("pready does not track the access phase");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error flag outside an answered access");
  chk_err_decode: assert property (acc |-> pslverr == !mapped)
    else $error("error flag does not match address decode");
  chk_unmapped_zero: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read returned nonzero data");
  chk_ien_readback: assert property (acc && !pwrite && paddr == `ADDR_IEN && !dlab
    |-> prdata[3:0] == ien[3:0])
    else $error("enable register read differs from last write");
  chk_modem_outputs: assert property (acc && pwrite && paddr == `ADDR_MCR
    |=> rts_n == !$past(pwdata[1]) && dtr_n == !$past(pwdata[0]))
    else $error("modem outputs do not follow modem control");
  chk_irq_masked: assert property (irq |-> ien[3:0] != 4'h0)
    else $error("interrupt raised with no source enabled");
  chk_modem_irq: assert property ($changed(dsr_n) && ien[3] |-> ##[1:6] irq)
    else $error("modem change did not raise the interrupt");
endmodule

// [serial_partner.sv]
// ==========================================================================
// Remote serial device: sends frames on rxd, samples frames from txd.
module serial_partner (
  input wire pclk,
  input wire txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  int bit_clks = 32;

  // The line idles high between frames.
  initial rxd = 1'b1;

  // Sends eight data bits; a low stop bit is cut short so that the receiver
  // sees a framing fault without mistaking the tail for a new start.
  task automatic send(input logic [7:0] d, input logic stop);
    @(posedge pclk);
    rxd <= 1'b0;
    repeat (bit_clks) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      rxd <= d[i];
      repeat (bit_clks) @(posedge pclk);
    end
    rxd <= stop;
    repeat (stop ? bit_clks : bit_clks * 5 / 8) @(posedge pclk);
    rxd <= 1'b1;
  endtask

  // Collects n bits after the start bit, each sampled in mid-bit.
  task automatic recv(input int n, output logic [9:0] b);
    b = 10'h3FF;
    while (txd !== 1'b0) @(posedge pclk);
    repeat (bit_clks / 2) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      repeat (bit_clks) @(posedge pclk);
      b[i] = txd;
    end
  endtask
endmodule

// [async_serial_port_baud_gen_tb_top.sv]
`include "uart_regs.vh"

module async_serial_port_baud_gen_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] exp_sel = 3'h0;
  logic [3:0] modem_n = 4'hF;
  wire [31:0] prdata;
  wire pready, pslverr, rxd, txd, rts_n, dtr_n, irq;
  int err_total = 0;
  int num_checks = 0;
  int seed = 32'h4DDDD5E6;
  logic last_err;
  logic [31:0] v;
  logic [31:0] w;
  logic [7:0] lcr;
  logic [7:0] d;
  logic [31:0] ra [9] = '{`ADDR_DATA, `ADDR_IEN, `ADDR_IID, `ADDR_LCR, `ADDR_MCR,
    `ADDR_LSR, `ADDR_MSR, `ADDR_SCR, `ADDR_FRAC};
  logic [31:0] fr [3] = '{32'h8C00, 32'h9000, 32'h0};
  int bc [3] = '{96, 128, 64};

  async_serial_port async_serial_port_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .clock_div_exponent(exp_sel), .rxd, .txd,
    .cts_n(modem_n[0]), .dsr_n(modem_n[1]), .ri_n(modem_n[2]), .dcd_n(modem_n[3]),
    .rts_n, .dtr_n, .irq);
  serial_partner serial_partner_i (.pclk, .txd, .rxd);

  // Free-running 50 MHz clock.
  initial forever #10 pclk = ~pclk;

  // ==========================================================================
  // Bus cycles and comparisons
  task automatic apb(input logic wt, input logic [31:0] a, input logic [31:0] dt,
      output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wt;
    paddr <= a;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] dt);
    logic [31:0] r;
    apb(1'b1, a, dt, r);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] r);
    apb(1'b0, a, 32'h0, r);
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Expected line bits after the start: data, optional parity, stop high.
  function automatic logic [9:0] frame(input logic [7:0] dd, input logic [7:0] l);
    int n;
    logic [7:0] m;
    n = l[1:0] + 5;
    m = 8'hFF >> (8 - n);
    frame = {2'h3, dd & m} | (10'h3FF << n);
    if (l[3]) frame[n] = l[5] ? !l[4] : ^(dd & m) ^ !l[4];
  endfunction

  // Divisor is written through the shared bank, then its low byte is read back there.
  task automatic setdiv(input logic [15:0] dv, input logic [7:0] l);
    logic [31:0] r;
    wr(`ADDR_LCR, 32'h80);
    wr(`ADDR_DATA, {24'h0, dv[7:0]});
    wr(`ADDR_IEN, {24'h0, dv[15:8]});
    rd(`ADDR_DATA, r);
    check(r, {24'h0, dv[7:0]});
    wr(`ADDR_LCR, {24'h0, l});
  endtask
  task automatic txframe(input logic [7:0] dd, input logic [7:0] l);
    logic [9:0] got;
    wr(`ADDR_DATA, {24'h0, dd});
    serial_partner_i.recv(l[1:0] + 6 + l[3], got);
    check({22'h0, got}, {22'h0, frame(dd, l)});
  endtask
  task automatic toggle(input int k);
    @(posedge pclk);
    modem_n[k] <= 1'b0;
    repeat (6) @(posedge pclk);
    modem_n[k] <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i], v);
      check(v, (ra[i] == `ADDR_LSR) ? 32'h60 : 32'h0);
    end
    repeat (4) begin
      v = $random(seed);
      wr(`ADDR_SCR, v);
      rd(`ADDR_SCR, w);
      check(w, {24'h0, v[7:0]});
      wr(`ADDR_MCR, v & 32'h3);
      @(negedge pclk);
      check({30'h0, rts_n, dtr_n}, {30'h0, ~v[1:0]});
    end
    wr(32'hFFFF0720, 32'hFF);
    check({31'h0, last_err}, 32'h1);
    rd(32'hFFFF0720, w);
    check(w, 32'h0);
    // Random frame formats at three prescale settings, empty interrupt each time.
    wr(`ADDR_IEN, 32'h2);
    for (int k = 0; k < 8; k++) begin
      lcr = $random(seed) & 8'h3F;
      d = $random(seed);
      exp_sel <= 3'(k % 3);
      serial_partner_i.bit_clks = 32 << (k % 3);
      setdiv(16'h1, lcr);
      txframe(d, lcr);
      rd(`ADDR_IID, w);
      check(w, 32'h2);
      check({31'h0, irq}, 32'h1);
      wr(`ADDR_IID, 32'h2);
      @(negedge pclk);
      check({31'h0, irq}, 32'h0);
    end
    // Fractional stretch of 1.5 and 2, then back to the plain divisor.
    exp_sel <= 3'h0;
    setdiv(16'h2, 8'h03);
    for (int k = 0; k < 3; k++) begin
      wr(`ADDR_FRAC, fr[k]);
      rd(`ADDR_FRAC, w);
      check(w, fr[k]);
      serial_partner_i.bit_clks = bc[k];
      d = $random(seed);
      txframe(d, 8'h03);
    end
    // Reception: a clean frame, then one with a framing fault.
    setdiv(16'h1, 8'h03);
    serial_partner_i.bit_clks = 32;
    wr(`ADDR_IID, 32'hF);
    wr(`ADDR_IEN, 32'h5);
    d = $random(seed) | 8'h01;
    serial_partner_i.send(d, 1'b1);
    @(negedge pclk);
    check({31'h0, irq}, 32'h1);
    rd(`ADDR_IID, w);
    check(w, 32'h1);
    rd(`ADDR_DATA, w);
    check(w, {24'h0, d});
    rd(`ADDR_LSR, w);
    check(w, 32'h60);
    wr(`ADDR_IID, 32'h1);
    serial_partner_i.send(d, 1'b0);
    rd(`ADDR_IID, w);
    check(w, 32'h5);
    rd(`ADDR_LSR, w);
    check(w, 32'h69);
    rd(`ADDR_DATA, w);
    wr(`ADDR_IID, 32'h5);
    @(negedge pclk);
    check({31'h0, irq}, 32'h0);
    // Modem inputs one at a time; the clear-to-send delta lies outside the source.
    wr(`ADDR_IEN, $random(seed) & 32'hF0 | 32'h8);
    for (int k = 0; k < 4; k++) begin
      toggle(k);
      rd(`ADDR_IID, w);
      check(w, (k == 0) ? 32'h0 : 32'h8);
      rd(`ADDR_MSR, w);
      check(w, 32'h1 << k);
      wr(`ADDR_IID, 32'h8);
    end
    wr(`ADDR_IEN, 32'hF0);
    toggle(1);
    @(negedge pclk);
    check({31'h0, irq}, 32'h0);
    // Break forces the idle line low; txd is registered, so wait two edges.
    wr(`ADDR_LCR, 32'h43);
    repeat (2) @(negedge pclk);
    check({31'h0, txd}, 32'h0);
    final_report();
  end

  // Cuts a hang short well beyond the expected run of some 10000 cycles.
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    final_report();
  end
endmodule

bind async_serial_port async_serial_port_monitor async_serial_port_monitor_i (.pclk,
  .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .dsr_n, .rts_n, .dtr_n, .irq);
